// [design/temp_sensor_pkg.sv]
// shared constants and types for the temperature sensor register block
package temp_sensor_pkg;
  // register selector codes
  localparam logic [7:0] SEL_TEMP = 8'h00;
  localparam logic [7:0] SEL_CONFIG = 8'h01;
  localparam logic [7:0] SEL_HYST = 8'h02;
  localparam logic [7:0] SEL_OVERTEMP = 8'h03;
  localparam logic [7:0] SEL_ONESHOT = 8'h04;
  // reset values
  localparam logic [7:0] SELECTOR_RESET = 8'h00;
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [15:0] HYST_RESET = 16'h4B00;
  localparam logic [15:0] OVERTEMP_RESET = 16'h5000;
  // configuration field positions
  localparam int CFG_SHUTDOWN = 0;
  localparam int CFG_INT_MODE = 1;
  localparam int CFG_POLARITY = 2;
  localparam int CFG_FQ_LO = 3;
  localparam int CFG_FQ_HI = 4;
  localparam int CFG_ONESHOT = 5;
  // fault queue depths per field code
  localparam logic [2:0] FQ_DEPTH_0 = 3'h1;
  localparam logic [2:0] FQ_DEPTH_1 = 3'h2;
  localparam logic [2:0] FQ_DEPTH_2 = 3'h4;
  localparam logic [2:0] FQ_DEPTH_3 = 3'h6;
  // timing
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int CONV_PERIOD_MS = 100;
  localparam int ONESHOT_WAIT_MS = 60;
  localparam int CONV_PERIOD_CYCLES = CONV_PERIOD_MS * (CLK_FREQ_HZ / 1000);
  // link request kinds
  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ = 2'h2
  } link_op_t;
  // one byte-level request from the link
  typedef struct packed {
    link_op_t op;
    logic [7:0] data;
  } link_req_t;
  // conversion engine states
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_CONV = 3'b010,
    ST_REST = 3'b100
  } conv_state_t;
endpackage

// [design/temp_sensor_regs.sv]
// register set, conversion sequencing and alert logic of the sensor
// How it works
// - one-shot bit powers down, no auto conversions
// - selector write 0x04 runs one conversion
// - one-shot location reads latest result
// - one-shot write may raise the alert
// - interrupt mode: any read clears alert
// - comparator mode: below hysteresis clears alert
// - fault queue needs consecutive over-limit results
// - config 8 bits, others 16 bits
// - result read-only, the rest read/write
// - selector loads 0x00 at reset
// - limits reset 0x4B00 and 0x5000
// - selector low bits choose target register
// - selector is write-only, never read back
// - result held as two's complement
// - result sent upper byte then lower
// - config holds all mode settings, read/write
// - shutdown bit stops, clearing restarts conversion
// - mode bit: comparator or interrupt
// - polarity bit: alert active low or high
// - fault field 00 one fault, 01 two
module temp_sensor_regs #(
  parameter int PERIOD_CYCLES = temp_sensor_pkg::CONV_PERIOD_CYCLES
) (
  // core clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // byte link, on the link clock
  input wire logic link_clk,
  input wire logic link_req_valid,
  input wire temp_sensor_pkg::link_req_t link_req,
  output logic link_ready_reg,
  output logic link_rd_valid_reg,
  output logic [7:0] link_rd_data_reg,
  // converter front end
  output logic conv_start_reg,
  output logic conv_power_reg,
  input wire logic conv_done_tgl,
  input wire logic [11:0] conv_code,
  // open-drain alert pin
  output logic overtemp_alert_output_reg,
  output logic overtemp_alert_oe_reg
);
  // refuse periods the timer cannot hold
  generate
    if (PERIOD_CYCLES < 2 || PERIOD_CYCLES > 16777215) begin : g_chk
      $error("PERIOD_CYCLES out of range");
    end
  endgenerate

  // link-domain state
  logic lrst_s1, lrst_s2; // reset brought onto the link clock
  logic ack_s1, ack_s2, ack_s3; // ack toggle synchroniser
  logic req_tgl_reg; // request toggle, one flip per request
  temp_sensor_pkg::link_req_t payload_reg; // held until acknowledged

  // core-domain state
  logic req_s1, req_s2, req_s3; // request toggle synchroniser
  logic ack_tgl_reg; // acknowledge toggle
  logic [7:0] ack_data_reg; // read byte, stable while link samples
  logic done_s1, done_s2, done_s3; // converter done synchroniser
  logic [7:0] selector_reg; // write-only register selector
  logic first_byte_reg; // next written byte goes to the selector
  logic byte_idx_reg; // 0 upper byte, 1 lower byte
  logic [15:0] temp_reg;
  logic [7:0] cfg_reg;
  logic [15:0] hyst_reg;
  logic [15:0] overtemp_reg;
  logic os_pend_reg; // one-shot request waiting for the engine
  temp_sensor_pkg::conv_state_t state_reg, state_next;
  logic [23:0] timer_reg; // cycles since the last conversion start
  logic [2:0] fault_cnt_reg, fault_cnt_next;
  logic alert_active_reg; // alert asserted, before polarity
  logic int_wait_low_reg; // interrupt mode waits for the low crossing

  // decoded events
  logic cmd_evt, done_evt, wr_ptr_evt, wr_data_evt, rd_evt;
  logic [11:0] result_code;
  logic [15:0] result_word;
  logic over_limit, below_hyst, trip, alert_set, auto_mode;
  logic [2:0] fq_depth;

  // link clock: reset and ack synchronisers
  always_ff @(posedge link_clk) begin
    lrst_s1 <= sys_rst;
    lrst_s2 <= lrst_s1;
    ack_s1 <= ack_tgl_reg;
    ack_s2 <= ack_s1;
    ack_s3 <= ack_s2;
  end

  // link clock: accept one request at a time, wait for its ack
  always_ff @(posedge link_clk) begin
    if (lrst_s2) begin
      req_tgl_reg <= 1'b0;
      payload_reg <= '0;
      link_ready_reg <= 1'b1;
      link_rd_valid_reg <= 1'b0;
      link_rd_data_reg <= 8'h00;
    end else begin
      link_rd_valid_reg <= 1'b0;
      if (link_req_valid && link_ready_reg) begin
        // payload stays put until the core answers
        req_tgl_reg <= ~req_tgl_reg;
        payload_reg <= link_req;
        link_ready_reg <= 1'b0;
      end else if (!link_ready_reg && (ack_s2 != ack_s3)) begin
        link_ready_reg <= 1'b1;
        if (payload_reg.op == temp_sensor_pkg::OP_READ) begin
          // ack_data_reg is frozen by the handshake here
          link_rd_valid_reg <= 1'b1;
          link_rd_data_reg <= ack_data_reg;
        end
      end
    end
  end

  // core clock: request and converter synchronisers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
    end else if (clk_en) begin
      req_s1 <= req_tgl_reg;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      done_s1 <= conv_done_tgl;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
    end
  end

  // event decode and comparisons
  always_comb begin
    cmd_evt = clk_en && (req_s2 != req_s3);
    done_evt = clk_en && (done_s2 != done_s3) &&
               (state_reg == temp_sensor_pkg::ST_CONV);
    wr_ptr_evt = cmd_evt && first_byte_reg &&
                 (payload_reg.op == temp_sensor_pkg::OP_WRITE);
    wr_data_evt = cmd_evt && !first_byte_reg &&
                  (payload_reg.op == temp_sensor_pkg::OP_WRITE);
    rd_evt = cmd_evt && (payload_reg.op == temp_sensor_pkg::OP_READ);
    result_code = conv_code;
    result_word = {result_code, 4'h0};
    // signed compare: the top bit is the sign
    over_limit = $signed(result_word) > $signed(overtemp_reg);
    below_hyst = $signed(result_word) < $signed(hyst_reg);
    auto_mode = !cfg_reg[temp_sensor_pkg::CFG_SHUTDOWN] &&
                !cfg_reg[temp_sensor_pkg::CFG_ONESHOT];
    case (cfg_reg[temp_sensor_pkg::CFG_FQ_HI:temp_sensor_pkg::CFG_FQ_LO])
      2'h0: fq_depth = temp_sensor_pkg::FQ_DEPTH_0;
      2'h1: fq_depth = temp_sensor_pkg::FQ_DEPTH_1;
      2'h2: fq_depth = temp_sensor_pkg::FQ_DEPTH_2;
      default: fq_depth = temp_sensor_pkg::FQ_DEPTH_3;
    endcase
    // consecutive over-limit results, saturating at the deepest queue
    if (!over_limit) begin
      fault_cnt_next = 3'h0;
    end else if (fault_cnt_reg < temp_sensor_pkg::FQ_DEPTH_3) begin
      fault_cnt_next = fault_cnt_reg + 3'h1;
    end else begin
      fault_cnt_next = fault_cnt_reg;
    end
    trip = done_evt && over_limit && (fault_cnt_next >= fq_depth);
    // interrupt mode: one event per crossing, high then low
    if (cfg_reg[temp_sensor_pkg::CFG_INT_MODE]) begin
      alert_set = int_wait_low_reg ? (done_evt && below_hyst) :
                  trip;
    end else begin
      alert_set = trip;
    end
  end

  // core: transaction tracking and selector
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      selector_reg <= temp_sensor_pkg::SELECTOR_RESET;
      first_byte_reg <= 1'b0;
      byte_idx_reg <= 1'b0;
    end else if (cmd_evt) begin
      case (payload_reg.op)
        temp_sensor_pkg::OP_START: begin
          first_byte_reg <= 1'b1;
          byte_idx_reg <= 1'b0;
        end
        temp_sensor_pkg::OP_WRITE: begin
          if (first_byte_reg) begin
            selector_reg <= payload_reg.data;
            first_byte_reg <= 1'b0;
          end else begin
            byte_idx_reg <= ~byte_idx_reg;
          end
        end
        temp_sensor_pkg::OP_READ: byte_idx_reg <= ~byte_idx_reg;
        default: byte_idx_reg <= byte_idx_reg;
      endcase
    end
  end

  // core: handshake answer and read data; selector itself is never sent
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_tgl_reg <= 1'b0;
      ack_data_reg <= 8'h00;
    end else if (cmd_evt) begin
      ack_tgl_reg <= ~ack_tgl_reg;
      if (payload_reg.op == temp_sensor_pkg::OP_READ) begin
        case (selector_reg[2:0])
          3'h0, 3'h4: ack_data_reg <= byte_idx_reg ?
                        temp_reg[7:0] : temp_reg[15:8];
          3'h1: ack_data_reg <= cfg_reg;
          3'h2: ack_data_reg <= byte_idx_reg ?
                  hyst_reg[7:0] : hyst_reg[15:8];
          3'h3: ack_data_reg <= byte_idx_reg ?
                  overtemp_reg[7:0] : overtemp_reg[15:8];
          default: ack_data_reg <= 8'h00;
        endcase
      end
    end
  end

  // core: writable registers; result is written by conversions only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_reg <= temp_sensor_pkg::CONFIG_RESET;
      hyst_reg <= temp_sensor_pkg::HYST_RESET;
      overtemp_reg <= temp_sensor_pkg::OVERTEMP_RESET;
    end else if (wr_data_evt) begin
      case (selector_reg[2:0])
        3'h1: cfg_reg <= payload_reg.data;
        // low nibble of a limit is not part of the code
        3'h2: begin
          if (byte_idx_reg) hyst_reg[7:0] <= payload_reg.data & 8'hF0;
          else hyst_reg[15:8] <= payload_reg.data;
        end
        3'h3: begin
          if (byte_idx_reg) overtemp_reg[7:0] <= payload_reg.data & 8'hF0;
          else overtemp_reg[15:8] <= payload_reg.data;
        end
        default: cfg_reg <= cfg_reg;
      endcase
    end
  end

  // core: latest conversion result
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      temp_reg <= temp_sensor_pkg::TEMP_RESET;
    end else if (done_evt) begin
      temp_reg <= result_word;
    end
  end

  // core: pending one-shot; set beats the engine's clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      os_pend_reg <= 1'b0;
    end else if (wr_ptr_evt && payload_reg.data == temp_sensor_pkg::SEL_ONESHOT
                 && cfg_reg[temp_sensor_pkg::CFG_ONESHOT]) begin
      os_pend_reg <= 1'b1;
    end else if (clk_en && state_reg == temp_sensor_pkg::ST_OFF &&
                 state_next == temp_sensor_pkg::ST_CONV) begin
      os_pend_reg <= 1'b0;
    end
  end

  // conversion engine next state
  always_comb begin
    case (state_reg)
      temp_sensor_pkg::ST_OFF: begin
        if (cfg_reg[temp_sensor_pkg::CFG_SHUTDOWN])
          state_next = temp_sensor_pkg::ST_OFF;
        else if (auto_mode || os_pend_reg)
          state_next = temp_sensor_pkg::ST_CONV;
        else
          state_next = temp_sensor_pkg::ST_OFF;
      end
      temp_sensor_pkg::ST_CONV: begin
        if (cfg_reg[temp_sensor_pkg::CFG_SHUTDOWN])
          state_next = temp_sensor_pkg::ST_OFF;
        else if (done_evt)
          state_next = auto_mode ? temp_sensor_pkg::ST_REST :
                       temp_sensor_pkg::ST_OFF;
        else
          state_next = temp_sensor_pkg::ST_CONV;
      end
      temp_sensor_pkg::ST_REST: begin
        if (!auto_mode)
          state_next = temp_sensor_pkg::ST_OFF;
        else if (timer_reg >= 24'(PERIOD_CYCLES - 1))
          state_next = temp_sensor_pkg::ST_CONV;
        else
          state_next = temp_sensor_pkg::ST_REST;
      end
      default: state_next = temp_sensor_pkg::ST_OFF;
    endcase
  end

  // conversion engine registers and converter controls
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= temp_sensor_pkg::ST_OFF;
      timer_reg <= 24'h000000;
      conv_start_reg <= 1'b0;
      conv_power_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      // start pulse and period restart on entry to a conversion
      conv_start_reg <= (state_next == temp_sensor_pkg::ST_CONV) &&
                        (state_reg != temp_sensor_pkg::ST_CONV);
      conv_power_reg <= state_next == temp_sensor_pkg::ST_CONV;
      if (state_next == temp_sensor_pkg::ST_CONV &&
          state_reg != temp_sensor_pkg::ST_CONV)
        timer_reg <= 24'h000000;
      else if (timer_reg != 24'hFFFFFF)
        timer_reg <= timer_reg + 24'h000001;
    end
  end

  // fault queue and alert state; a new event wins over a read clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_cnt_reg <= 3'h0;
      alert_active_reg <= 1'b0;
      int_wait_low_reg <= 1'b0;
    end else if (clk_en) begin
      if (done_evt)
        fault_cnt_reg <= fault_cnt_next;
      if (!cfg_reg[temp_sensor_pkg::CFG_INT_MODE]) begin
        int_wait_low_reg <= 1'b0;
        if (alert_set)
          alert_active_reg <= 1'b1;
        else if (done_evt && below_hyst)
          alert_active_reg <= 1'b0;
      end else begin
        if (alert_set) begin
          alert_active_reg <= 1'b1;
          int_wait_low_reg <= ~int_wait_low_reg;
        end else if (rd_evt) begin
          alert_active_reg <= 1'b0;
        end
      end
    end
  end

  // open-drain pin: polarity applied, driven only when low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      overtemp_alert_output_reg <= 1'b0;
      overtemp_alert_oe_reg <= 1'b0;
    end else if (clk_en) begin
      overtemp_alert_output_reg <= 1'b0;
      overtemp_alert_oe_reg <= cfg_reg[temp_sensor_pkg::CFG_POLARITY] ?
                               !alert_active_reg : alert_active_reg;
    end
  end

  // checks
  property p_reset_values;
    @(posedge clk) sys_rst |=> selector_reg == 8'h00 && temp_reg == 16'h0000
      && cfg_reg == 8'h00 && hyst_reg == 16'h4B00 && overtemp_reg == 16'h5000;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("reset values wrong");

  property p_oneshot_idle;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == temp_sensor_pkg::ST_OFF && cfg_reg[5] && !os_pend_reg)
      |=> state_reg == temp_sensor_pkg::ST_OFF;
  endproperty
  a_oneshot_idle: assert property (p_oneshot_idle)
    else $error("conversion started in one-shot mode without trigger");

  property p_oneshot_trigger;
    @(posedge clk) disable iff (sys_rst)
      (wr_ptr_evt && payload_reg.data == 8'h04 && cfg_reg[5] && !cfg_reg[0])
      |=> ##[1:3] conv_start_reg;
  endproperty
  a_oneshot_trigger: assert property (p_oneshot_trigger)
    else $error("one-shot write did not start a conversion");

  property p_shutdown_stops;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && cfg_reg[0]) |=> state_reg == temp_sensor_pkg::ST_OFF;
  endproperty
  a_shutdown_stops: assert property (p_shutdown_stops)
    else $error("engine running during shutdown");

  property p_oneshot_read;
    @(posedge clk) disable iff (sys_rst)
      (rd_evt && selector_reg == 8'h04 && !byte_idx_reg)
      |=> ack_data_reg == $past(temp_reg[15:8]);
  endproperty
  a_oneshot_read: assert property (p_oneshot_read)
    else $error("one-shot read differs from result");

  property p_lower_byte;
    @(posedge clk) disable iff (sys_rst)
      (rd_evt && selector_reg == 8'h00 && byte_idx_reg)
      |=> ack_data_reg == $past(temp_reg[7:0]);
  endproperty
  a_lower_byte: assert property (p_lower_byte)
    else $error("second result byte is not the lower byte");

  property p_result_readonly;
    @(posedge clk) disable iff (sys_rst)
      (wr_data_evt && selector_reg == 8'h00 && !done_evt) |=> $stable(temp_reg);
  endproperty
  a_result_readonly: assert property (p_result_readonly)
    else $error("result register was written");

  property p_int_read_clear;
    @(posedge clk) disable iff (sys_rst)
      (rd_evt && cfg_reg[1] && !alert_set) |=> !alert_active_reg;
  endproperty
  a_int_read_clear: assert property (p_int_read_clear)
    else $error("read did not clear interrupt alert");

  property p_fault_queue;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && !cfg_reg[1] && $rose(alert_active_reg))
      |-> $past(done_evt && fault_cnt_next >= fq_depth);
  endproperty
  a_fault_queue: assert property (p_fault_queue)
    else $error("alert rose before fault queue filled");

  property p_config_write;
    @(posedge clk) disable iff (sys_rst)
      (wr_data_evt && selector_reg == 8'h01)
      |=> cfg_reg == $past(payload_reg.data);
  endproperty
  a_config_write: assert property (p_config_write)
    else $error("configuration write lost");

  property p_selector_load;
    @(posedge clk) disable iff (sys_rst)
      wr_ptr_evt |=> selector_reg == $past(payload_reg.data) && !first_byte_reg;
  endproperty
  a_selector_load: assert property (p_selector_load)
    else $error("first byte did not load selector");

  c_oneshot_conv: cover property (@(posedge clk) disable iff (sys_rst)
    cfg_reg[5] && conv_start_reg);
  c_alert_rise: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(alert_active_reg));
  c_int_clear: cover property (@(posedge clk) disable iff (sys_rst)
    cfg_reg[1] && alert_active_reg ##1 !alert_active_reg);
  c_link_read: cover property (@(posedge link_clk) disable iff (lrst_s2)
    link_rd_valid_reg);
endmodule

// [test/link_master_model.sv]
// link master model: issues byte requests on the link clock
module link_master_model (
  // link clock
  input wire logic link_clk,
  // request side
  output logic link_req_valid,
  output temp_sensor_pkg::link_req_t link_req,
  // answer side
  input wire logic link_ready_reg,
  // raised when the block never answers
  output logic hang
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle at time zero
  initial begin
    link_req_valid = 1'b0;
    link_req = '0;
    hang = 1'b0;
  end
  // one request, held until taken, then released with flipped data
  task automatic xfer(input logic [1:0] op, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge link_clk);
    link_req_valid = 1'b1;
    link_req.op = temp_sensor_pkg::link_op_t'(op);
    link_req.data = d;
    @(posedge link_clk);
    // hold until ready is sampled high
    while (link_ready_reg !== 1'b1 && n < 50) begin
      n++;
      @(posedge link_clk);
    end
    @(negedge link_clk);
    link_req_valid = 1'b0;
    // stale data never lingers on the lines
    link_req.data = ~d;
    // next request only after the answer
    while (link_ready_reg !== 1'b1 && n < 100) begin
      n++;
      @(posedge link_clk);
    end
    if (n >= 100) hang = 1'b1;
  endtask
endmodule

// [test/temp_sensor_regs_oneshot_test.sv]
// self-checking bench of the sensor register block
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  failures++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module temp_sensor_regs_oneshot_test;
  timeunit 1ns;
  timeprecision 1ps;
  // short conversion period keeps the run small
  localparam int PER = 200;
  // clocks, reset and inputs
  logic clk = 1'b0, link_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
  logic conv_done_tgl = 1'b0;
  logic [11:0] conv_code = 12'h000;
  // link and outputs
  logic link_req_valid, link_ready_reg, link_rd_valid_reg, hang;
  temp_sensor_pkg::link_req_t link_req;
  logic [7:0] link_rd_data_reg, e;
  logic conv_start_reg, conv_power_reg, alert, oe;
  // bookkeeping
  int failures = 0, total_checks = 0, starts = 0, cnt = 0, base = 0;
  // last two read bytes, oldest in the upper half
  logic [15:0] last_word = 16'h0000;
  logic [31:0] seed = 32'd33307;
  logic [31:0] r;
  logic [7:0] exp_q[$];
  always #5 clk = ~clk;
  always #6 link_clk = ~link_clk;
  temp_sensor_regs #(.PERIOD_CYCLES(PER)) temp_sensor_regs_i (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .link_clk(link_clk),
    .link_req_valid(link_req_valid), .link_req(link_req),
    .link_ready_reg(link_ready_reg), .link_rd_valid_reg(link_rd_valid_reg),
    .link_rd_data_reg(link_rd_data_reg), .conv_start_reg(conv_start_reg),
    .conv_power_reg(conv_power_reg), .conv_done_tgl(conv_done_tgl),
    .conv_code(conv_code), .overtemp_alert_output_reg(alert),
    .overtemp_alert_oe_reg(oe));
  link_master_model link_master_model_i (.link_clk(link_clk),
    .link_req_valid(link_req_valid), .link_req(link_req),
    .link_ready_reg(link_ready_reg), .hang(hang));
  // converter stand-in: finishes 20 clk after each start
  always @(negedge clk) begin
    if (cnt == 1) conv_done_tgl <= ~conv_done_tgl;
    if (cnt != 0) cnt <= cnt - 1;
    if (conv_start_reg === 1'b1) begin
      starts <= starts + 1;
      cnt <= 20;
    end
  end
  // read byte monitor against the oldest note
  always @(posedge link_clk) begin
    if (link_rd_valid_reg === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("[ERR] rd_extra exp none got %h", link_rd_data_reg);
      end else begin
        e = exp_q.pop_front();
        last_word = {last_word[7:0], link_rd_data_reg};
        `CHK("rd_data", e, link_rd_data_reg)
      end
    end
  end
  // a stuck link ends the run
  always @(posedge hang) begin
    failures++;
    report_and_stop();
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // read at the current selector, upper byte first
  task automatic rdraw(input logic [15:0] v, input bit two);
    link_master_model_i.xfer(2'h0, 8'h00);
    if (two) begin
      exp_q.push_back(v[15:8]);
      link_master_model_i.xfer(2'h2, 8'h00);
    end
    exp_q.push_back(v[7:0]);
    link_master_model_i.xfer(2'h2, 8'h00);
  endtask
  // unused selector bits are always written as zero
  task automatic wr(input logic [7:0] sel, input logic [15:0] v, bit two);
    link_master_model_i.xfer(2'h0, 8'h00);
    link_master_model_i.xfer(2'h1, sel);
    if (two) link_master_model_i.xfer(2'h1, v[15:8]);
    link_master_model_i.xfer(2'h1, v[7:0]);
  endtask
  task automatic rd(input logic [7:0] sel, input logic [15:0] v, bit two);
    link_master_model_i.xfer(2'h0, 8'h00);
    link_master_model_i.xfer(2'h1, sel);
    rdraw(v, two);
  endtask
  // conversion starts counted from a base taken by the caller
  task automatic quiet(input int s, input int w, input int d);
    repeat (w) @(negedge clk);
    `CHK("starts", s + d, starts)
  endtask
  // one-shot trigger, wait for the result, then look at the pin
  task automatic shot(input logic [11:0] c, input logic want_oe);
    int s, n;
    s = starts;
    n = 0;
    // converter input moves on the core clock's falling edge
    @(negedge clk);
    conv_code = c;
    link_master_model_i.xfer(2'h0, 8'h00);
    link_master_model_i.xfer(2'h1, 8'h04);
    // wait out the conversion before any read
    while (conv_power_reg !== 1'b0 && n < 300) begin
      n++;
      @(negedge clk);
    end
    if (n >= 300) begin
      failures++;
      report_and_stop();
    end
    repeat (8) @(negedge clk);
    `CHK("starts", s + 1, starts)
    `CHK("alert_oe", want_oe, oe)
    `CHK("alert_out", 1'b0, alert)
  endtask
  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    repeat (10) @(negedge link_clk);
    rdraw(16'h0000, 1);
    rd(8'h01, 16'h0000, 0);
    rd(8'h02, 16'h4B00, 1);
    rd(8'h03, 16'h5000, 1);
    $display("test reset done");
    r = xs();
    wr(8'h02, {1'b0, r[14:0]}, 1);
    rd(8'h02, {1'b0, r[14:4], 4'h0}, 1);
    wr(8'h00, r[31:16], 1);
    rd(8'h00, 16'h0000, 1);
    $display("test access done");
    wr(8'h01, 8'h22, 0);
    rd(8'h01, 16'h0022, 0);
    quiet(starts, 300, 0);
    shot(12'h7D0, 1'b1);
    rd(8'h04, 16'h7D00, 1);
    repeat (8) @(negedge clk);
    `CHK("alert_oe", 1'b0, oe)
    $display("test interrupt done");
    wr(8'h01, 8'h20, 0);
    shot(12'h7D0, 1'b1);
    shot(12'hE70, 1'b0);
    rd(8'h00, 16'hE700, 1);
    // reader side: the code read back is minus 25 degrees in every format
    repeat (2) @(negedge clk);
    `CHK("deg12", -25, (int'(last_word[15:4]) - 4096) / 16)
    `CHK("deg9", -25, (int'(last_word[15:7]) - 512) / 2)
    `CHK("deg8", -25, int'(last_word[15:8]) - 256)
    $display("test comparator done");
    wr(8'h01, 8'h28, 0);
    shot(12'h7D0, 1'b0);
    shot(12'h7D0, 1'b1);
    wr(8'h01, 8'h2C, 0);
    repeat (8) @(negedge clk);
    `CHK("alert_oe", 1'b0, oe)
    // deeper queues: four and six consecutive faults
    wr(8'h01, 8'h30, 0);
    shot(12'hE70, 1'b0);
    repeat (3) shot(12'h7D0, 1'b0);
    shot(12'h7D0, 1'b1);
    wr(8'h01, 8'h38, 0);
    shot(12'hE70, 1'b0);
    repeat (5) shot(12'h7D0, 1'b0);
    shot(12'h7D0, 1'b1);
    $display("test queue done");
    wr(8'h01, 8'h01, 0);
    quiet(starts, 300, 0);
    // the restart pulse comes before the write task returns
    base = starts;
    wr(8'h01, 8'h00, 0);
    quiet(base, 20, 1);
    // frozen core must hold off the next periodic start
    clk_en = 1'b0;
    quiet(starts, 300, 0);
    clk_en = 1'b1;
    $display("test shutdown done");
    `CHK("pending", 0, exp_q.size())
    report_and_stop();
  end
endmodule
